// File: logic/timer_dual_capture_results.sv
// Result registers, count measurement and flag clearing for two capture inputs.
// Assumes a single-slave AHB-Lite bus, timer value and RTC stamp on ref_clk,
// and asynchronous capture pins that are synchronised here.
//
// How it works
// - Input one count result: cycles minus one
// - Input two count result: cycles minus one
// - Input one capture stores timer counter value
// - Input one capture stores RTC low part
// - Input one capture stores RTC high part
// - Input two capture stores timer counter value
// - Input two capture stores RTC low part
// - Input two capture stores RTC high part
// - Clear bit 2 clears input two flags
// - Clear bit 1 clears input one flags
// - Clear bit 0 clears timer pending flag
// - Window spans period count plus one periods
// - Event while pending sets overrun, keeps result
// - Pending flag sticks until software clears it
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
module timer_dual_capture_results
    import timer_capture_pkg::*;
(
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // AHB-Lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // Capture pins
    input  wire logic                 capture_input_one,
    input  wire logic                 capture_input_two,
    // Timer core
    input  wire logic [VALUE_W-1:0]   timer_value,
    input  wire logic [STAMP_W-1:0]   rtc_stamp,
    input  wire logic                 timer_tick,
    output logic                      input_one_pending,
    output logic                      input_two_pending,
    output logic                      input_one_overrun,
    output logic                      input_two_overrun,
    output logic                      timer_pending,
    // Interrupt
    output logic                      irq
);

    logic [31:0]        capture_config;
    logic [FLAG_W-1:0]  irq_status;
    logic [FLAG_W-1:0]  irq_enable;
    logic               data_write;
    logic [31:0]        data_addr;
    logic [STAMP_W-1:0] result [CHANS];
    logic               pend   [CHANS];
    logic               ovr    [CHANS];
    wire  [CHANS-1:0]   chan_ev;
    wire  [CHANS-1:0]   chan_ovr_ev;
    wire  [CHANS-1:0]   clear_chan;
    wire  [CHANS-1:0]   pin_in;

    // Bus decode; hsize is not checked, only whole words are mapped
    wire         addr_phase = hsel & hready & htrans[HTRANS_ACTIVE_BIT];
    wire  [31:0] word_addr  = haddr & WORD_MASK;
    wire         wr_clear   = data_write & (data_addr == ADDR_EVENT_CLEAR);
    wire         wr_config  = data_write & (data_addr == ADDR_CAPTURE_CONFIG);
    wire         wr_irq_clr = data_write & (data_addr == ADDR_IRQ_CLEAR);
    wire         wr_irq_en  = data_write & (data_addr == ADDR_IRQ_ENABLE);

    // Only ones act; zero bits leave the flags alone
    assign clear_chan[0] = wr_clear & hwdata[CLR_IN1_BIT];
    assign clear_chan[1] = wr_clear & hwdata[CLR_IN1_BIT + 1];
    wire   clear_timer   = wr_clear & hwdata[CLR_TIMER_BIT];
    assign pin_in        = {capture_input_two, capture_input_one};

    wire [FLAG_W-1:0] flag_now  = {ovr[1], ovr[0], pend[1], pend[0], timer_pending};
    wire [FLAG_W-1:0] irq_set   = {chan_ovr_ev, chan_ev, timer_tick};
    wire [FLAG_W-1:0] irq_wclr  = wr_irq_clr ? hwdata[FLAG_W-1:0] : {FLAG_W{1'b0}};
    wire [FLAG_W-1:0] next_irq_status = (irq_status & ~irq_wclr) | irq_set;

    // The clear register and irq clear read back as zero
    wire [31:0] read_mux =
        (word_addr == ADDR_IN1_RESULT)     ? {{(32-STAMP_W){1'b0}}, result[0]} :
        (word_addr == ADDR_IN2_RESULT)     ? {{(32-STAMP_W){1'b0}}, result[1]} :
        (word_addr == ADDR_CAPTURE_CONFIG) ? capture_config :
        (word_addr == ADDR_FLAG_STATUS)    ? {{(32-FLAG_W){1'b0}}, flag_now} :
        (word_addr == ADDR_IRQ_STATUS)     ? {{(32-FLAG_W){1'b0}}, irq_status} :
        (word_addr == ADDR_IRQ_ENABLE)     ? {{(32-FLAG_W){1'b0}}, irq_enable} :
        READ_ZERO;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            data_write <= 1'b0;
            data_addr  <= READ_ZERO;
            hrdata     <= READ_ZERO;
        end else begin
            data_write <= addr_phase & hwrite;
            data_addr  <= word_addr;
            if (addr_phase & ~hwrite) begin
                hrdata <= read_mux;
            end
        end
    end

    // Zero-wait slave, always OKAY
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            capture_config <= CONFIG_RESET;
            irq_enable     <= {FLAG_W{1'b0}};
        end else begin
            if (wr_config) begin
                capture_config <= hwdata;
            end
            if (wr_irq_en) begin
                irq_enable <= hwdata[FLAG_W-1:0];
            end
        end
    end

    // Sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_status <= {FLAG_W{1'b0}};
            irq        <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq        <= |(next_irq_status & irq_enable);
        end
    end

    // Timer pending; set wins over clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            timer_pending <= 1'b0;
        end else begin
            timer_pending <= (timer_pending & ~clear_timer) | timer_tick;
        end
    end

    for (genvar c = 0; c < CHANS; c++) begin : chan
        localparam int BASE = c * CFG_CHAN_STRIDE;
        logic                s1;
        logic                s2;
        logic                s3;
        logic                armed;
        logic [VALUE_W-1:0]  cycles;
        logic [PERIOD_W-1:0] periods;

        wire                count_mode   = capture_config[BASE + CFG_COUNT_BIT];
        wire                fall         = capture_config[BASE + CFG_FALL_BIT];
        wire                stamp_select = capture_config[BASE + CFG_STAMP_BIT];
        wire [PERIOD_W-1:0] period_count =
            capture_config[BASE + CFG_PERIOD_LSB +: PERIOD_W];
        wire edge_seen = fall ? (s3 & ~s2) : (s2 & ~s3);
        // Completion on the edge that closes period_count + 1 periods
        wire done      = count_mode & armed & edge_seen & (periods == period_count);
        wire ev        = (~count_mode & edge_seen) | done;
        wire pend_left = pend[c] & ~clear_chan[c];

        // Count: cycles already reads N-1 on the closing edge
        // Capture: counter or RTC low part, RTC high part above
        wire [VALUE_W-1:0] lower = count_mode   ? cycles :
                                   stamp_select ? rtc_stamp[VALUE_W-1:0] : timer_value;
        wire [VALUE_W-1:0] upper = count_mode ? UPPER_UNUSED
                                              : rtc_stamp[STAMP_W-1:VALUE_W];

        assign chan_ev[c]     = ev;
        assign chan_ovr_ev[c] = ev & pend_left;

        // Only s2 and s3 are read; s1 feeds s2 alone
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                s1 <= 1'b0;
                s2 <= 1'b0;
                s3 <= 1'b0;
            end else begin
                s1 <= pin_in[c];
                s2 <= s1;
                s3 <= s2;
            end
        end

        // Measurement restarts on the closing edge; cycles saturate on slow inputs
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                armed   <= 1'b0;
                cycles  <= '0;
                periods <= '0;
            end else if (!count_mode) begin
                armed   <= 1'b0;
                cycles  <= '0;
                periods <= '0;
            end else begin
                if (edge_seen) begin
                    armed <= 1'b1;
                end
                if (edge_seen & (~armed | done)) begin
                    cycles  <= '0;
                    periods <= '0;
                end else begin
                    if (cycles != CYCLES_MAX) begin
                        cycles <= VALUE_W'(cycles + 1'b1);
                    end
                    if (edge_seen) begin
                        periods <= PERIOD_W'(periods + 1'b1);
                    end
                end
            end
        end

        // Set beats clear; a second event only flags overrun
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                pend[c]   <= 1'b0;
                ovr[c]    <= 1'b0;
                result[c] <= RESULT_RESET;
            end else begin
                pend[c] <= pend_left | ev;
                ovr[c]  <= (ovr[c] & ~clear_chan[c]) | (ev & pend_left);
                if (ev & ~pend_left) begin
                    result[c] <= {upper, lower};
                end
            end
        end
    end

    assign input_one_pending = pend[0];
    assign input_two_pending = pend[1];
    assign input_one_overrun = ovr[0];
    assign input_two_overrun = ovr[1];

endmodule

// File: logic/timer_capture_pkg.sv
// Constants for the dual capture/count result block.
// Assumes a word-aligned AHB-Lite map and an 11-bit timer core.
package timer_capture_pkg;

    // Byte addresses of the word registers
    localparam logic [31:0] ADDR_IN1_RESULT     = 32'h5000_400c;
    localparam logic [31:0] ADDR_IN2_RESULT     = 32'h5000_4010;
    localparam logic [31:0] ADDR_EVENT_CLEAR    = 32'h5000_4014;
    localparam logic [31:0] ADDR_CAPTURE_CONFIG = 32'h5000_4018;
    localparam logic [31:0] ADDR_FLAG_STATUS    = 32'h5000_401c;
    localparam logic [31:0] ADDR_IRQ_STATUS     = 32'h5000_4020;
    localparam logic [31:0] ADDR_IRQ_CLEAR      = 32'h5000_4024;
    localparam logic [31:0] ADDR_IRQ_ENABLE     = 32'h5000_4028;
    localparam logic [31:0] WORD_MASK           = 32'hffff_fffc;

    // Widths
    localparam int CHANS    = 2;
    localparam int VALUE_W  = 11;
    localparam int STAMP_W  = 22;
    localparam int PERIOD_W = 6;
    localparam int FLAG_W   = 5;

    // Event-clear register bits
    localparam int CLR_TIMER_BIT = 0;
    localparam int CLR_IN1_BIT   = 1;

    // Capture configuration, one 16-bit lane per input
    localparam int CFG_CHAN_STRIDE = 16;
    localparam int CFG_COUNT_BIT   = 0;
    localparam int CFG_FALL_BIT    = 1;
    localparam int CFG_STAMP_BIT   = 2;
    localparam int CFG_PERIOD_LSB  = 3;

    // Flag layout shared by flag status, irq status, clear and enable
    localparam int FLG_TIMER_BIT = 0;
    localparam int FLG_PEND_LSB  = 1;
    localparam int FLG_OVR_LSB   = 3;

    // Reset values and fixed patterns
    localparam logic [31:0]        CONFIG_RESET = 32'h0000_0000;
    localparam logic [STAMP_W-1:0] RESULT_RESET = 22'h00_0000;
    localparam logic [VALUE_W-1:0] UPPER_UNUSED = 11'h000;
    localparam logic [VALUE_W-1:0] CYCLES_MAX   = 11'h7ff;
    localparam logic [31:0]        READ_ZERO    = 32'h0000_0000;
    localparam int                 HTRANS_ACTIVE_BIT = 1;

endpackage

// File: test/pin_source.sv
// Far-side pin model: square wave on each capture pin while run is high.
// Assumes the bench owns run; pins rest low outside bursts.
`timescale 1ns/100ps
module pin_source #(
    parameter int PERIOD = 10
) (
    // Clock and control
    input  wire logic       ref_clk,
    input  wire logic [1:0] run,
    // Capture pins
    output logic            capture_input_one,
    output logic            capture_input_two
);
    int cnt = 0;
    initial {capture_input_one, capture_input_two} = 2'b00;
    // Half-period levels stay far above the two-cycle minimum the sync needs
    always @(posedge ref_clk) begin
        cnt <= (cnt + 1) % PERIOD;
        capture_input_one <= run[0] && cnt < PERIOD / 2;
        capture_input_two <= run[1] && cnt < PERIOD / 2;
    end
endmodule

// File: test/timer_results_chk.sv
// Checker for flag clearing, stickiness and the clear register read path.
// Assumes the block is bound below by its own port names.
`timescale 1ns/100ps
module timer_results_chk
    import timer_capture_pkg::*;
(
    // Clock, reset and bus
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    // Flags
    input wire logic        timer_tick,
    input wire logic        input_one_pending,
    input wire logic        input_one_overrun,
    input wire logic        input_two_overrun,
    input wire logic        timer_pending
);
    logic clr_wr;
    logic clr_rd;
    wire  hit = hsel && hready && htrans[1] && (haddr & WORD_MASK) == ADDR_EVENT_CLEAR;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            clr_wr <= 1'b0;
            clr_rd <= 1'b0;
        end else begin
            clr_wr <= hit && hwrite;
            clr_rd <= hit && !hwrite;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_clear_reads_zero: assert property (clr_rd |-> hrdata == READ_ZERO)
        else $error("clear register read not zero");
    a_clear_one_ovr: assert property (clr_wr && hwdata[1] |=> !input_one_overrun)
        else $error("input one overrun not cleared");
    a_clear_two_ovr: assert property (clr_wr && hwdata[2] |=> !input_two_overrun)
        else $error("input two overrun not cleared");
    a_clear_timer: assert property (clr_wr && hwdata[0] && !timer_tick |=> !timer_pending)
        else $error("timer flag not cleared");
    a_tick_sets: assert property (timer_tick |=> timer_pending)
        else $error("timer flag not set");
    a_timer_sticky: assert property (timer_pending && !(clr_wr && hwdata[0]) |=> timer_pending)
        else $error("timer flag dropped");
    a_one_sticky: assert property (input_one_pending && !(clr_wr && hwdata[1]) |=> input_one_pending)
        else $error("input one flag dropped");
    a_overrun_pend: assert property ($rose(input_one_overrun) |-> input_one_pending)
        else $error("overrun without pending");
    a_zero_keeps: assert property (clr_wr && !hwdata[1] && input_one_overrun |=> input_one_overrun)
        else $error("zero write cleared overrun");
endmodule
bind timer_dual_capture_results timer_results_chk timer_results_chk_inst (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .timer_tick(timer_tick), .input_one_pending(input_one_pending),
    .input_one_overrun(input_one_overrun), .input_two_overrun(input_two_overrun),
    .timer_pending(timer_pending));

// File: test/tb_top.sv
// Bench for the dual capture result block: AHB-Lite tasks and checked sequences.
// Assumes the pin source model drives the capture pins.
`timescale 1ns/100ps
module tb_top import timer_capture_pkg::*;;
    localparam int PERIOD = 10;
    logic               ref_clk, rst, hsel, hwrite, hreadyout, hresp, timer_tick, irq, tp;
    logic [1:0]         htrans, run;
    logic [31:0]        haddr, hwdata, hrdata, q, exp;
    logic [VALUE_W-1:0] timer_value;
    logic [STAMP_W-1:0] rtc_stamp;
    wire  [1:0]         pend, ovr, pin;
    int                 fails, n_compared, cycles, per, ch;
    logic [31:0]        addr [4] = '{ADDR_IN1_RESULT, ADDR_IN2_RESULT, ADDR_EVENT_CLEAR, 32'h5000_4030};

    timer_dual_capture_results timer_dual_capture_results_inst (
        .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .capture_input_one(pin[0]), .capture_input_two(pin[1]),
        .timer_value(timer_value), .rtc_stamp(rtc_stamp), .timer_tick(timer_tick),
        .input_one_pending(pend[0]), .input_two_pending(pend[1]),
        .input_one_overrun(ovr[0]), .input_two_overrun(ovr[1]),
        .timer_pending(tp), .irq(irq));
    pin_source #(.PERIOD(PERIOD)) pin_source_inst (
        .ref_clk(ref_clk), .run(run), .capture_input_one(pin[0]), .capture_input_two(pin[1]));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (fails == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask
    // Single word transfer; the bench timeout ends any hang
    task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wait_pend(int c);
        for (int i = 0; i < 200 && pend[c] !== 1'b1; i++) @(posedge ref_clk);
    endtask

    initial begin
        {rst, hsel, hwrite, timer_tick, htrans, run} = 8'h80;
        {haddr, hwdata, fails, n_compared, cycles} = '0;
        timer_value = 11'h5a3;
        rtc_stamp = 22'h2a_b5c;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        foreach (addr[i]) begin
            bus(0, addr[i], 0);
            check("reset read", q, 0);
        end
        for (int k = 0; k < 4; k++) begin
            ch = k & 1;
            bus(1, ADDR_CAPTURE_CONFIG, 32'(((k >> 1) * 4) << (16 * ch)));
            exp = {10'h0, rtc_stamp[21:11], k > 1 ? rtc_stamp[10:0] : timer_value};
            run[ch] <= 1'b1;
            wait_pend(ch);
            // Move both sources so a late overwrite would show
            timer_value <= timer_value + 11'h111;
            rtc_stamp <= rtc_stamp + 22'h1_0101;
            repeat (25) @(posedge ref_clk);
            run[ch] <= 1'b0;
            repeat (8) @(posedge ref_clk);
            bus(1, ADDR_EVENT_CLEAR, 0);
            @(posedge ref_clk);
            check("overrun kept", {pend[ch], ovr[ch]}, 2'b11);
            bus(0, ADDR_IN1_RESULT + 32'(4 * ch), 0);
            check("capture result", q, exp);
            bus(1, ADDR_EVENT_CLEAR, 32'h2 << ch);
            @(posedge ref_clk);
            check("flags cleared", {pend[ch], ovr[ch]}, 0);
        end
        for (int k = 0; k < 4; k++) begin
            ch = k & 1;
            per = (k >> 1) * 2;
            bus(1, ADDR_CAPTURE_CONFIG, 32'((per * 8 + 1) << (16 * ch)));
            run[ch] <= 1'b1;
            wait_pend(ch);
            run[ch] <= 1'b0;
            repeat (8) @(posedge ref_clk);
            bus(0, ADDR_IN1_RESULT + 32'(4 * ch), 0);
            check("count result", q, 32'((per + 1) * PERIOD - 1));
            bus(1, ADDR_EVENT_CLEAR, 32'h6);
        end
        bus(1, ADDR_IRQ_ENABLE, 32'h1);
        timer_tick <= 1'b1;
        @(posedge ref_clk);
        timer_tick <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check("timer flag and irq", {tp, irq}, 2'b11);
        bus(1, ADDR_IRQ_ENABLE, 0);
        repeat (2) @(posedge ref_clk);
        check("masked irq", irq, 0);
        bus(1, ADDR_IRQ_CLEAR, 32'h1f);
        bus(1, ADDR_EVENT_CLEAR, 32'h1);
        @(posedge ref_clk);
        check("timer flag cleared", tp, 0);
        bus(0, ADDR_IRQ_STATUS, 0);
        check("irq status cleared", q, 0);
        check("okay response", hresp, 0);
        print_verdict();
    end
endmodule
